// [watchdog_pkg.sv]
`default_nettype none
package watchdog_pkg;

  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  localparam int unsigned FLAG_BIT     = 7;
  localparam int unsigned IRQ_EN_BIT   = 6;
  localparam int unsigned PSC_MSB_BIT  = 5;
  localparam int unsigned UNLOCK_BIT   = 4;
  localparam int unsigned RST_EN_BIT   = 3;
  localparam int unsigned PSC_LOW_HI   = 2;
  localparam int unsigned PSC_LOW_LO   = 0;

  localparam int unsigned STAT_MODE_LO = 0;
  localparam int unsigned STAT_WINDOW  = 2;
  localparam int unsigned STAT_IRQ     = 3;
  localparam int unsigned STAT_FUSE    = 4;

  localparam logic       FLAG_RESET     = 1'b0;
  localparam logic       IRQ_EN_RESET   = 1'b0;
  localparam logic       RST_EN_RESET   = 1'b0;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;

  localparam logic [2:0] UNLOCK_CYCLES     = 3'h4;
  localparam int unsigned COUNT_W          = 21;
  localparam logic [4:0] BASE_TIMEOUT_LOG2 = 5'h0B;
  localparam logic [3:0] PRESCALE_MAX_CODE = 4'h9;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

  typedef enum logic [1:0] {
    MODE_STOPPED   = 2'b00,
    MODE_IRQ       = 2'b01,
    MODE_IRQ_RESET = 2'b11,
    MODE_RESET     = 2'b10
  } mode_t;

  // Terminal count: oscillator cycles of the selected time-out, minus one
  function automatic logic [COUNT_W-1:0] prescale_term(input logic [3:0] code);
    logic [3:0]         code_eff;
    logic [COUNT_W-1:0] one;
    code_eff = (code > PRESCALE_MAX_CODE) ? PRESCALE_MAX_CODE : code;
    one      = COUNT_W'(1);
    return (one << (BASE_TIMEOUT_LOG2 + {1'b0, code_eff})) - one;
  endfunction : prescale_term

endpackage : watchdog_pkg
`default_nettype wire

// [watchdog_sync.sv]
`default_nettype none
module watchdog_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : watchdog_sync
`default_nettype wire

// [watchdog_counter.sv]
`default_nettype none
module watchdog_counter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [3:0] code,
  output logic            expire
);

  logic [watchdog_pkg::COUNT_W-1:0] count_q;
  logic [watchdog_pkg::COUNT_W-1:0] count_d;
  logic [watchdog_pkg::COUNT_W-1:0] term;
  logic                             at_term;

  assign term    = watchdog_pkg::prescale_term(code);
  // Compare with >= so a shorter time-out chosen mid-count still expires
  assign at_term = (count_q >= term);
  assign count_d = clear ? '0 : (tick ? (at_term ? '0 : count_q + 1'b1) : count_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      expire  <= 1'b0;
    end else begin
      count_q <= count_d;
      expire  <= tick & at_term & ~clear;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_expire_at_term;
    expire |-> $past(count_q) >= $past(term) && count_q == '0;
  endproperty
  a_expire_at_term: assert property (p_expire_at_term)
    else $error("expiry without reaching terminal count");

endmodule : watchdog_counter
`default_nettype wire

// [watchdog_timer_control.sv]
`default_nettype none
// Summary of operation
// - Control byte: flag 7, irq enable 6, prescale msb 5, unlock 4, reset enable 3
// - Time-out in an interrupt mode sets the interrupt flag
// - CPU vectoring to the watchdog handler clears the flag
// - Writing one clears the flag; writing zero leaves it
// - Interrupt request needs CPU global enable and watchdog irq enable
// - Enables decode: stopped, interrupt, reset, interrupt then reset
// - Interrupt-and-reset: first time-out sets flag; vectoring clears enable and flag
// - Interrupt-and-reset: unserviced flag at next time-out issues system reset
// - Clock monitor with any enable forces reset mode, no interrupt
// - Always-on fuse forces reset mode regardless of enable bits
// - Reset enable clear or prescale change only while unlock set
// - Unlock clears itself four clock cycles after being written
// - Reset-cause flag forces reset enable to one
// - Prescale code selects 2048 oscillator cycles doubling up to 1048576
// - Watchdog system reset goes to reset vector address zero
// - Counter counts a separate slow oscillator, not the system clock
module watchdog_timer_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdog_osc,
  input  wire logic        wdr_strobe,
  input  wire logic        cpu_global_irq_en,
  input  wire logic        irq_vector_ack,
  input  wire logic        always_on_fuse,
  input  wire logic        clock_monitor_on,
  input  wire logic        timeout_reset_cause_flag,
  output logic             timeout_irq_req,
  output logic             system_reset_req,
  output logic      [15:0] reset_vector_addr
);

  logic                     osc_s;
  logic                     fuse_s;
  logic                     clkmon_s;
  logic                     osc_prev_q;
  logic                     tick;
  logic                     expire;

  logic                     flag_q;
  logic                     flag_d;
  logic                     irq_en_q;
  logic                     irq_en_d;
  logic                     rst_en_q;
  logic                     rst_en_d;
  logic [3:0]               prescale_q;
  logic [3:0]               prescale_d;
  logic [2:0]               window_q;
  logic [2:0]               window_d;
  logic [31:0]              prdata_q;
  logic                     reset_q;
  logic [15:0]              vector_q;

  watchdog_pkg::mode_t      mode;
  logic                     any_enable;
  logic                     irq_mode;
  logic                     window_open;
  logic                     sel_ctrl;
  logic                     sel_stat;
  logic                     unmapped;
  logic                     access;
  logic                     wr_ctrl;
  logic                     unlock_wr;
  logic                     set_flag;
  logic                     clr_flag;
  logic                     fire_reset;
  logic [7:0]               ctrl_rd;
  logic [7:0]               stat_rd;
  logic [31:0]              rd_data;

  // Oscillator, fuse and monitor come from outside this clock
  watchdog_sync #(
    .WIDTH (3)
  ) watchdog_sync_inst (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({wdog_osc, always_on_fuse, clock_monitor_on}),
    .sync_out ({osc_s, fuse_s, clkmon_s})
  );

  assign tick = osc_s & ~osc_prev_q;

  watchdog_counter watchdog_counter_inst (
    .clk    (pclk),
    .rst_n  (presetn),
    .tick   (tick),
    .clear  (wdr_strobe | (mode == watchdog_pkg::MODE_STOPPED)),
    .code   (prescale_q),
    .expire (expire)
  );

  // Mode decode
  assign any_enable = fuse_s | rst_en_q | irq_en_q;
  assign mode = (clkmon_s & any_enable) ? watchdog_pkg::MODE_RESET :
                fuse_s                  ? watchdog_pkg::MODE_RESET :
                watchdog_pkg::mode_t'({rst_en_q, irq_en_q});
  assign irq_mode = (mode == watchdog_pkg::MODE_IRQ) | (mode == watchdog_pkg::MODE_IRQ_RESET);

  // APB decode, zero wait states
  assign sel_ctrl  = (paddr == watchdog_pkg::CTRL_OFFSET);
  assign sel_stat  = (paddr == watchdog_pkg::STATUS_OFFSET);
  assign unmapped  = ~sel_ctrl & ~sel_stat;
  assign access    = psel & penable;
  assign wr_ctrl   = access & pwrite & sel_ctrl;
  assign unlock_wr = wr_ctrl & pwdata[watchdog_pkg::UNLOCK_BIT]
                     & pwdata[watchdog_pkg::RST_EN_BIT];
  assign pready    = 1'b1;
  assign pslverr   = access & unmapped;
  assign prdata    = prdata_q;

  assign window_open = (window_q != 3'h0);

  // Time-out actions
  assign set_flag   = expire & ((mode == watchdog_pkg::MODE_IRQ) |
                      ((mode == watchdog_pkg::MODE_IRQ_RESET) & ~flag_q));
  assign fire_reset = expire & ((mode == watchdog_pkg::MODE_RESET) |
                      ((mode == watchdog_pkg::MODE_IRQ_RESET) & flag_q));
  assign clr_flag   = irq_vector_ack | (wr_ctrl & pwdata[watchdog_pkg::FLAG_BIT]);
  // A time-out in the same cycle as a clear is kept
  assign flag_d     = set_flag | (flag_q & ~clr_flag);

  // Vectoring in interrupt-and-reset drops the enable; a later write re-arms it
  assign irq_en_d = fuse_s ? 1'b0 :
                    wr_ctrl ? pwdata[watchdog_pkg::IRQ_EN_BIT] :
                    (irq_vector_ack & (mode == watchdog_pkg::MODE_IRQ_RESET)) ? 1'b0 :
                    irq_en_q;

  // Setting the reset enable is always allowed, clearing only in the window
  assign rst_en_d = timeout_reset_cause_flag ? 1'b1 :
                    (wr_ctrl & pwdata[watchdog_pkg::RST_EN_BIT]) ? 1'b1 :
                    (wr_ctrl & window_open) ? 1'b0 :
                    rst_en_q;

  assign prescale_d = (wr_ctrl & window_open) ?
                      {pwdata[watchdog_pkg::PSC_MSB_BIT],
                       pwdata[watchdog_pkg::PSC_LOW_HI:watchdog_pkg::PSC_LOW_LO]} :
                      prescale_q;

  assign window_d = unlock_wr   ? watchdog_pkg::UNLOCK_CYCLES :
                    window_open ? window_q - 3'h1 : 3'h0;

  assign ctrl_rd = {flag_q, irq_en_q, prescale_q[3], window_open,
                    rst_en_q | fuse_s, prescale_q[2:0]};
  assign stat_rd = {3'h0, fuse_s, timeout_irq_req, window_open, mode};
  assign rd_data = sel_ctrl ? {24'h0, ctrl_rd} :
                   sel_stat ? {24'h0, stat_rd} : 32'h0;

  assign timeout_irq_req   = flag_q & irq_en_q & cpu_global_irq_en & irq_mode;
  assign system_reset_req  = reset_q;
  assign reset_vector_addr = vector_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q     <= watchdog_pkg::FLAG_RESET;
      irq_en_q   <= watchdog_pkg::IRQ_EN_RESET;
      rst_en_q   <= watchdog_pkg::RST_EN_RESET;
      prescale_q <= watchdog_pkg::PRESCALE_RESET;
      window_q   <= 3'h0;
    end else begin
      flag_q     <= flag_d;
      irq_en_q   <= irq_en_d;
      rst_en_q   <= rst_en_d;
      prescale_q <= prescale_d;
      window_q   <= window_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
      reset_q    <= 1'b0;
      vector_q   <= watchdog_pkg::RESET_VECTOR_ADDR;
      prdata_q   <= 32'h0;
    end else begin
      osc_prev_q <= osc_s;
      reset_q    <= fire_reset;
      vector_q   <= watchdog_pkg::RESET_VECTOR_ADDR;
      if (psel & ~penable & ~pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unlock;
    wr_ctrl && pwdata[watchdog_pkg::UNLOCK_BIT] && pwdata[watchdog_pkg::RST_EN_BIT];
  endsequence

  sequence s_quiet_window;
    (!unlock_wr) [*4];
  endsequence

  property p_irq_layout;
    wr_ctrl && !fuse_s |=> ctrl_rd[6] == $past(pwdata[6]);
  endproperty
  a_irq_layout: assert property (p_irq_layout)
    else $error("irq enable not at bit 6");

  property p_flag_set;
    expire && mode == watchdog_pkg::MODE_IRQ |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("time-out did not set flag");

  property p_ack_clear;
    irq_vector_ack && !set_flag |=> !flag_q;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("vectoring did not clear flag");

  property p_write_zero_keeps;
    flag_q && wr_ctrl && !pwdata[7] && !irq_vector_ack |=> flag_q;
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps)
    else $error("writing zero cleared flag");

  property p_irq_gate;
    timeout_irq_req |-> cpu_global_irq_en && irq_en_q && flag_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request without both enables");

  property p_stopped;
    mode == watchdog_pkg::MODE_STOPPED |-> !rst_en_q && !irq_en_q && !fuse_s;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped with an enable set");

  property p_vector_leaves;
    irq_vector_ack && mode == watchdog_pkg::MODE_IRQ_RESET && !wr_ctrl |=> !irq_en_q;
  endproperty
  a_vector_leaves: assert property (p_vector_leaves)
    else $error("enable kept after vectoring");

  property p_second_timeout;
    expire && flag_q && mode == watchdog_pkg::MODE_IRQ_RESET |=> system_reset_req;
  endproperty
  a_second_timeout: assert property (p_second_timeout)
    else $error("unserviced time-out gave no reset");

  property p_clock_monitor;
    clkmon_s && any_enable |-> mode == watchdog_pkg::MODE_RESET && !timeout_irq_req;
  endproperty
  a_clock_monitor: assert property (p_clock_monitor)
    else $error("clock monitor did not force reset mode");

  property p_fuse;
    fuse_s |-> mode == watchdog_pkg::MODE_RESET;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("fuse did not force reset mode");

  property p_locked;
    wr_ctrl && !window_open |=> prescale_q == $past(prescale_q);
  endproperty
  a_locked: assert property (p_locked)
    else $error("prescale changed without unlock");

  property p_window_open;
    s_unlock |=> window_open [*4];
  endproperty
  a_window_open: assert property (p_window_open)
    else $error("unlock window shorter than four cycles");

  property p_window_close;
    s_unlock ##1 s_quiet_window |=> !window_open;
  endproperty
  a_window_close: assert property (p_window_close)
    else $error("unlock window longer than four cycles");

  property p_cause_forces;
    timeout_reset_cause_flag |=> rst_en_q ##1 (rst_en_q || !$past(timeout_reset_cause_flag));
  endproperty
  a_cause_forces: assert property (p_cause_forces)
    else $error("reset enable low while cause flag set");

  property p_vector;
    system_reset_req |-> reset_vector_addr == watchdog_pkg::RESET_VECTOR_ADDR;
  endproperty
  a_vector: assert property (p_vector)
    else $error("reset vector not zero");

  property p_tick_single;
    tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("oscillator edge longer than one cycle");

  property p_write_one_clears;
    wr_ctrl && pwdata[watchdog_pkg::FLAG_BIT] && !set_flag |=> !flag_q;
  endproperty
  a_write_one_clears: assert property (p_write_one_clears)
    else $error("writing one did not clear flag");

  property p_first_timeout;
    expire && mode == watchdog_pkg::MODE_IRQ_RESET && !flag_q
      |=> flag_q && !system_reset_req;
  endproperty
  a_first_timeout: assert property (p_first_timeout)
    else $error("first time-out did not only set flag");

  property p_reset_mode_fire;
    expire && mode == watchdog_pkg::MODE_RESET |=> system_reset_req;
  endproperty
  a_reset_mode_fire: assert property (p_reset_mode_fire)
    else $error("reset mode time-out gave no reset");

  property p_stopped_quiet;
    mode == watchdog_pkg::MODE_STOPPED |=> !expire;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet)
    else $error("stopped watchdog expired");

  property p_ack_to_reset_mode;
    irq_vector_ack && mode == watchdog_pkg::MODE_IRQ_RESET && !wr_ctrl && !set_flag
      |=> !flag_q && mode == watchdog_pkg::MODE_RESET;
  endproperty
  a_ack_to_reset_mode: assert property (p_ack_to_reset_mode)
    else $error("vectoring did not leave reset mode only");

  property p_rst_en_locked;
    wr_ctrl && !window_open && rst_en_q |=> rst_en_q;
  endproperty
  a_rst_en_locked: assert property (p_rst_en_locked)
    else $error("reset enable cleared without unlock");

  property p_window_prescale;
    wr_ctrl && window_open |=>
      prescale_q == {$past(pwdata[watchdog_pkg::PSC_MSB_BIT]),
                     $past(pwdata[watchdog_pkg::PSC_LOW_HI:watchdog_pkg::PSC_LOW_LO])};
  endproperty
  a_window_prescale: assert property (p_window_prescale)
    else $error("prescale not taken in open window");

endmodule : watchdog_timer_control
`default_nettype wire

// [watchdog_timer_control_tb.sv]
`default_nettype none
module watchdog_timer_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] CTRL = watchdog_pkg::CTRL_OFFSET;
  localparam logic [7:0] STAT = watchdog_pkg::STATUS_OFFSET;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        wdog_osc, wdr_strobe, cpu_global_irq_en, irq_vector_ack;
  logic        always_on_fuse, clock_monitor_on, timeout_reset_cause_flag;
  logic        timeout_irq_req, system_reset_req;
  logic [15:0] reset_vector_addr;
  logic [32:0] exp_q[$];
  int          miscompares, checks_done, osc_cnt;

  watchdog_timer_control watchdog_timer_control_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdog_osc(wdog_osc), .wdr_strobe(wdr_strobe),
    .cpu_global_irq_en(cpu_global_irq_en), .irq_vector_ack(irq_vector_ack),
    .always_on_fuse(always_on_fuse), .clock_monitor_on(clock_monitor_on),
    .timeout_reset_cause_flag(timeout_reset_cause_flag),
    .timeout_irq_req(timeout_irq_req), .system_reset_req(system_reset_req),
    .reset_vector_addr(reset_vector_addr));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xorshift

  task automatic check(input logic [32:0] seen, input logic [32:0] expd);
    checks_done++;
    if (seen !== expd) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic apb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_write(input logic [7:0] a, input logic [7:0] d);
    apb_xfer(a, 1'b1, {xorshift(seed) & 32'hFFFFFF00} | {24'h0, d});
    seed = xorshift(seed);
  endtask : apb_write

  // Expected {pslverr, prdata} goes to the queue; the monitor compares
  task automatic apb_read(input logic [7:0] a, input logic [32:0] expd);
    exp_q.push_back(expd);
    apb_xfer(a, 1'b0, 32'h0);
  endtask : apb_read

  // Second write lands inside the four-cycle window
  task automatic unlock_write(input logic [7:0] d);
    apb_write(CTRL, 8'h18);
    apb_write(CTRL, d);
  endtask : unlock_write

  // Counter held by wdr_strobe outside this task, so each run starts from zero
  task automatic run_to_timeout(input logic want_reset);
    int n;
    n = 0;
    osc_cnt = 0;
    wdr_strobe <= 1'b0;
    while ((want_reset ? system_reset_req : timeout_irq_req) !== 1'b1 && n < 13000) begin
      @(posedge pclk);
      n++;
    end
    check({32'h0, 1'(osc_cnt >= 2047 && osc_cnt <= 2049)}, 33'h1);
    check({32'h0, system_reset_req}, {32'h0, want_reset});
    wdr_strobe <= 1'b1;
    // One edge with the strobe high, so a following run starts from zero
    @(posedge pclk);
  endtask : run_to_timeout

  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask : end_test

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        check(33'h0, 33'h1);
      end else begin
        check({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  always @(posedge wdog_osc) begin
    if (!wdr_strobe) begin
      osc_cnt++;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Six pclk per osc period: the fastest legal rate keeps the run short
  initial begin
    wdog_osc = 1'b0;
    forever begin
      repeat (3) @(posedge pclk);
      wdog_osc <= ~wdog_osc;
    end
  end

  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [3:0] code;
    logic [7:0] val;
    {presetn, psel, penable, pwrite, irq_vector_ack} = '0;
    {always_on_fuse, clock_monitor_on, timeout_reset_cause_flag} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wdr_strobe = 1'b1;
    cpu_global_irq_en = 1'b1;
    seed = 32'h322202FA;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;

    apb_read(CTRL, 33'h0);
    apb_read(STAT, 33'h0);
    apb_read(8'h08, {1'b1, 32'h0});
    check({17'h0, reset_vector_addr}, 33'h0);
    end_test("reset");

    apb_write(CTRL, 8'h18);
    apb_read(CTRL, 33'h18);
    repeat (6) @(posedge pclk);
    apb_read(CTRL, 33'h08);
    apb_write(CTRL, 8'h00);
    apb_read(CTRL, 33'h08);
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      code = (i == 3) ? 4'h0 : seed[3:0];
      val = {2'b00, code[3], 2'b00, code[2:0]};
      unlock_write(val);
      apb_read(CTRL, {25'h0, val});
    end
    end_test("protect");

    apb_write(CTRL, 8'h40);
    apb_read(STAT, 33'h01);
    run_to_timeout(1'b0);
    check({32'h0, timeout_irq_req}, 33'h1);
    cpu_global_irq_en <= 1'b0;
    repeat (2) @(posedge pclk);
    check({32'h0, timeout_irq_req}, 33'h0);
    apb_read(CTRL, 33'hC0);
    apb_write(CTRL, 8'h40);
    apb_read(CTRL, 33'hC0);
    apb_write(CTRL, 8'hC0);
    apb_read(CTRL, 33'h40);
    cpu_global_irq_en <= 1'b1;
    end_test("irq");

    apb_write(CTRL, 8'h48);
    apb_read(STAT, 33'h03);
    run_to_timeout(1'b0);
    irq_vector_ack <= 1'b1;
    @(posedge pclk);
    irq_vector_ack <= 1'b0;
    apb_read(CTRL, 33'h08);
    apb_read(STAT, 33'h02);
    apb_write(CTRL, 8'h48);
    run_to_timeout(1'b0);
    run_to_timeout(1'b1);
    check({17'h0, reset_vector_addr}, 33'h0);
    @(posedge pclk);
    check({32'h0, system_reset_req}, 33'h0);
    end_test("irq_reset");

    apb_write(CTRL, 8'h80);
    unlock_write(8'h00);
    apb_read(CTRL, 33'h00);
    timeout_reset_cause_flag <= 1'b1;
    repeat (2) @(posedge pclk);
    apb_read(CTRL, 33'h08);
    unlock_write(8'h00);
    apb_read(CTRL, 33'h08);
    timeout_reset_cause_flag <= 1'b0;
    unlock_write(8'h00);
    apb_read(CTRL, 33'h00);
    always_on_fuse <= 1'b1;
    repeat (3) @(posedge pclk);
    apb_write(CTRL, 8'h40);
    apb_read(CTRL, 33'h08);
    apb_read(STAT, 33'h12);
    always_on_fuse <= 1'b0;
    clock_monitor_on <= 1'b1;
    repeat (3) @(posedge pclk);
    apb_write(CTRL, 8'h40);
    apb_read(STAT, 33'h02);
    check({32'h0, timeout_irq_req}, 33'h0);
    end_test("override");

    repeat (2) @(posedge pclk);
    tally_and_finish();
  end
endmodule : watchdog_timer_control_tb
`default_nettype wire
